/* design/eccr_regs.sv */
// Control and status register bank of a dual voice echo canceller.
// Assumes the serial microport front end hands over decoded byte writes and reads,
// one cycle each, synchronous to mclk; the cancellation engine supplies status bytes.
`timescale 1ns/1ps

// Contract
// - Register groups at 00h and 20h, read back
// - Extended delay cascades both cancellers
// - Freeze bit stops filter adaptation
// - Bypass passes inputs straight to outputs
// - Pad bit inserts 12 dB receive loss
// - Back-to-back bit selects back-to-back configuration
// - Noise-off bit stops comfort noise
// - Reset bit presets all registers, self-clears
// - Offset filter off bypasses DC filters
// - Narrowband off disables narrowband detector
// - Status registers read-only, reset to zero
// - Nonlinear processor off disables it
// - Phase check off accepts unreversed tone
// - Tone detection off disables tone detectors
module eccr_regs
    import eccr_pkg::*;
#(
    parameter int W = `ECCR_SAMPLE_W
) (
    input  wire logic                    mclk,           // Master clock, 40 MHz.
    input  wire logic                    sys_rst,        // Synchronous reset, active high.
    input  wire logic                    wr_en,          // Register write strobe.
    input  wire logic                    rd_en,          // Register read strobe.
    input  wire logic [`ECCR_ADDR_W-1:0] addr,           // Register address.
    input  wire logic [7:0]              wr_data,        // Write data.
    output logic      [7:0]              rd_data,        // Read data, valid with rd_valid.
    output logic                         rd_valid,       // Read answer strobe.
    input  wire logic [7:0]              state_a_in,     // Canceller A status from the engine.
    input  wire logic [7:0]              state_b_in,     // Canceller B status from the engine.
    output logic                         cascade,        // Cancellers joined into one long canceller.
    output logic                         b2b_config,     // Back-to-back configuration.
    output logic [1:0]                   freeze_adapt,   // Per canceller, adaptation frozen.
    output logic [1:0]                   noise_off,      // Per canceller, comfort noise off.
    output logic [1:0]                   ofs_filter_off, // Per canceller, DC filters bypassed.
    output logic [1:0]                   nb_det_off,     // Per canceller, narrowband detector off.
    output logic [1:0]                   nlp_off,        // Per canceller, nonlinear processor off.
    output logic [1:0]                   phase_chk_off,  // Per canceller, phase reversal not needed.
    output logic [1:0]                   tone_det_off,   // Per canceller, tone detectors off.
    output logic [1:0]                   auto_tone,      // Per canceller, automatic tone bypass.
    input  wire logic                    smp_valid,      // Sample strobe for both cancellers.
    input  wire logic [2*W-1:0]          send_in,        // Send inputs, A in low half.
    input  wire logic [2*W-1:0]          recv_in,        // Receive inputs, A in low half.
    input  wire logic [2*W-1:0]          send_proc,      // Engine send results, A in low half.
    input  wire logic [2*W-1:0]          recv_proc,      // Engine receive results, A in low half.
    output logic      [2*W-1:0]          send_out,       // Send outputs, A in low half.
    output logic      [2*W-1:0]          recv_out        // Receive outputs, A in low half.
);
    typedef struct packed {
        eccr_byte_t a_ctrl1;
        eccr_byte_t a_ctrl2;
        eccr_byte_t b_ctrl1;
        eccr_byte_t b_ctrl2;
        eccr_byte_t a_state;
        eccr_byte_t b_state;
        eccr_byte_t rd_data;
        logic       rd_valid;
        logic       cascade;
        logic       b2b_config;
        logic [1:0] freeze_adapt;
        logic [1:0] noise_off;
        logic [1:0] ofs_filter_off;
        logic [1:0] nb_det_off;
        logic [1:0] nlp_off;
        logic [1:0] phase_chk_off;
        logic [1:0] tone_det_off;
        logic [1:0] auto_tone;
        logic [1:0] bypass;
        logic [1:0] pad;
        logic [1:0] send_mute;
        logic [1:0] recv_mute;
    } eccr_st_t;

    eccr_st_t st;
    eccr_st_t next_st;

    // The whole bank's preset, shared by the pin reset and the soft reset bit.
    function automatic eccr_st_t preset();
        eccr_st_t p;
        p = '0;
        p.a_ctrl1 = `ECCR_A_CTRL1_RST;
        p.a_ctrl2 = `ECCR_CTRL2_RST;
        p.b_ctrl1 = `ECCR_B_CTRL1_RST;
        p.b_ctrl2 = `ECCR_CTRL2_RST;
        p.a_state = `ECCR_STATE_RST;
        p.b_state = `ECCR_STATE_RST;
        return p;
    endfunction

    function automatic eccr_byte_t read_mux(input eccr_st_t s, input logic [`ECCR_ADDR_W-1:0] a);
        case (a)
            `ECCR_A_CTRL1: read_mux = s.a_ctrl1;
            `ECCR_A_CTRL2: read_mux = s.a_ctrl2;
            `ECCR_A_STATE: read_mux = s.a_state;
            `ECCR_B_CTRL1: read_mux = s.b_ctrl1;
            `ECCR_B_CTRL2: read_mux = s.b_ctrl2;
            `ECCR_B_STATE: read_mux = s.b_state;
            default:       read_mux = 8'h00;
        endcase
    endfunction

    always_comb begin
        eccr_byte_t c1a;
        eccr_byte_t c1b;
        eccr_byte_t c2a;
        eccr_byte_t c2b;
        c1a = '0;
        c1b = '0;
        c2a = '0;
        c2b = '0;
        next_st = st;
        next_st.rd_valid = rd_en;
        next_st.rd_data = rd_en ? read_mux(st, addr) : 8'h00;
        // Status follows the engine; it is never written from the port.
        next_st.a_state = state_a_in;
        next_st.b_state = state_b_in;
        if (wr_en) begin
            case (addr)
                `ECCR_A_CTRL1: next_st.a_ctrl1 = wr_data;
                `ECCR_A_CTRL2: next_st.a_ctrl2 = wr_data;
                `ECCR_B_CTRL1: next_st.b_ctrl1 = wr_data;
                `ECCR_B_CTRL2: next_st.b_ctrl2 = wr_data;
                default: ;
            endcase
        end
        // A written reset bit replays power-up next cycle, which also clears the bit.
        if (st.a_ctrl1[`ECCR_C1_RESET] || st.b_ctrl1[`ECCR_C1_RESET]) begin
            next_st = preset();
            next_st.rd_valid = rd_en;
            next_st.rd_data = rd_en ? read_mux(st, addr) : 8'h00;
        end
        c1a = next_st.a_ctrl1;
        c1b = next_st.b_ctrl1;
        c2a = next_st.a_ctrl2;
        c2b = next_st.b_ctrl2;
        // Reserved bit 0 of B carries no function; only A's bit cascades.
        next_st.cascade        = c1a[`ECCR_C1_EXTDLY];
        // The host keeps both copies equal; A's copy is taken as the device setting.
        next_st.b2b_config     = c1a[`ECCR_C1_B2B];
        next_st.freeze_adapt   = {c1b[`ECCR_C1_FREEZE], c1a[`ECCR_C1_FREEZE]};
        next_st.noise_off      = {c1b[`ECCR_C1_NOISE_OFF], c1a[`ECCR_C1_NOISE_OFF]};
        next_st.bypass         = {c1b[`ECCR_C1_BYPASS], c1a[`ECCR_C1_BYPASS]};
        next_st.pad            = {c1b[`ECCR_C1_PAD], c1a[`ECCR_C1_PAD]};
        next_st.ofs_filter_off = {c2b[`ECCR_C2_OFS_OFF], c2a[`ECCR_C2_OFS_OFF]};
        next_st.nb_det_off     = {c2b[`ECCR_C2_NB_OFF], c2a[`ECCR_C2_NB_OFF]};
        next_st.nlp_off        = {c2b[`ECCR_C2_NLP_OFF], c2a[`ECCR_C2_NLP_OFF]};
        next_st.phase_chk_off  = {c2b[`ECCR_C2_PHASE_OFF], c2a[`ECCR_C2_PHASE_OFF]};
        next_st.tone_det_off   = {c2b[`ECCR_C2_TONE_OFF], c2a[`ECCR_C2_TONE_OFF]};
        next_st.auto_tone      = {c2b[`ECCR_C2_AUTO_TONE], c2a[`ECCR_C2_AUTO_TONE]};
        next_st.send_mute      = {c2b[`ECCR_C2_SEND_MUTE], c2a[`ECCR_C2_SEND_MUTE]};
        next_st.recv_mute      = {c2b[`ECCR_C2_RECV_MUTE], c2a[`ECCR_C2_RECV_MUTE]};
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            st <= preset();
        end else begin
            st <= next_st;
        end
    end

    assign rd_data        = st.rd_data;
    assign rd_valid       = st.rd_valid;
    assign cascade        = st.cascade;
    assign b2b_config     = st.b2b_config;
    assign freeze_adapt   = st.freeze_adapt;
    assign noise_off      = st.noise_off;
    assign ofs_filter_off = st.ofs_filter_off;
    assign nb_det_off     = st.nb_det_off;
    assign nlp_off        = st.nlp_off;
    assign phase_chk_off  = st.phase_chk_off;
    assign tone_det_off   = st.tone_det_off;
    assign auto_tone      = st.auto_tone;

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : gen_path
            eccr_path #(.W(W)) u_path (
                .mclk      (mclk),
                .sys_rst   (sys_rst),
                .bypass    (st.bypass[g]),
                .pad       (st.pad[g]),
                .send_mute (st.send_mute[g]),
                .recv_mute (st.recv_mute[g]),
                .smp_valid (smp_valid),
                .send_in   (send_in[g*W +: W]),
                .recv_in   (recv_in[g*W +: W]),
                .send_proc (send_proc[g*W +: W]),
                .recv_proc (recv_proc[g*W +: W]),
                .send_out  (send_out[g*W +: W]),
                .recv_out  (recv_out[g*W +: W])
            );
        end
    endgenerate

    // A soft reset in flight overrides any write of the same cycle, so checks on writes leave it out.
    logic soft_pend;
    assign soft_pend = st.a_ctrl1[`ECCR_C1_RESET] || st.b_ctrl1[`ECCR_C1_RESET];

    chk_ctrl_readback: assert property (@(posedge mclk) disable iff (sys_rst)
        wr_en && addr == `ECCR_A_CTRL2 && !soft_pend ##1 !wr_en ##1 rd_en && !wr_en && addr == `ECCR_A_CTRL2
        |=> rd_valid && rd_data == $past(wr_data, 3))
        else $error("control register readback mismatch");

    chk_rd_valid_pulse: assert property (@(posedge mclk) disable iff (sys_rst)
        1'b1 |=> rd_valid == $past(rd_en))
        else $error("read answer strobe not one cycle after the read");

    chk_unmapped_zero: assert property (@(posedge mclk) disable iff (sys_rst)
        rd_en && !(addr inside {`ECCR_A_CTRL1, `ECCR_A_CTRL2, `ECCR_A_STATE,
                                `ECCR_B_CTRL1, `ECCR_B_CTRL2, `ECCR_B_STATE})
        |=> rd_data == 8'h00)
        else $error("unmapped read did not return zero");

    chk_ctrl_hold: assert property (@(posedge mclk) disable iff (sys_rst)
        !wr_en && !soft_pend
        |=> $stable(st.a_ctrl1) && $stable(st.a_ctrl2) && $stable(st.b_ctrl1) && $stable(st.b_ctrl2))
        else $error("control register changed without a write");

    chk_state_read_only: assert property (@(posedge mclk) disable iff (sys_rst)
        rd_en && addr == `ECCR_B_STATE && !$past(soft_pend) |=> rd_data == $past(state_b_in, 2))
        else $error("status register not tracking engine");

    chk_state_no_write: assert property (@(posedge mclk) disable iff (sys_rst)
        wr_en && addr == `ECCR_A_STATE && !soft_pend |=> st.a_state == $past(state_a_in))
        else $error("status register took a port write");

    chk_soft_reset_clear: assert property (@(posedge mclk) disable iff (sys_rst)
        wr_en && addr == `ECCR_B_CTRL1 && wr_data[`ECCR_C1_RESET] && !soft_pend
        |=> ##1 st.b_ctrl1 == `ECCR_B_CTRL1_RST && st.a_ctrl1 == `ECCR_A_CTRL1_RST)
        else $error("soft reset did not preset registers");

    chk_preset_all: assert property (@(posedge mclk) disable iff (sys_rst)
        soft_pend
        |=> st.a_ctrl2 == `ECCR_CTRL2_RST && st.b_ctrl2 == `ECCR_CTRL2_RST && st.a_state == `ECCR_STATE_RST
            && !cascade && !b2b_config && freeze_adapt == 2'b00 && nlp_off == 2'b00)
        else $error("soft reset left a register or control set");

    chk_cascade_follow: assert property (@(posedge mclk) disable iff (sys_rst)
        wr_en && addr == `ECCR_A_CTRL1 && !wr_data[`ECCR_C1_RESET] && !soft_pend
        |=> cascade == $past(wr_data[`ECCR_C1_EXTDLY]))
        else $error("cascade not following control bit");

    chk_b2b_follow: assert property (@(posedge mclk) disable iff (sys_rst)
        wr_en && addr == `ECCR_A_CTRL1 && !wr_data[`ECCR_C1_RESET] && !soft_pend
        |=> b2b_config == $past(wr_data[`ECCR_C1_B2B]))
        else $error("back-to-back control mismatch");

    chk_freeze_follow: assert property (@(posedge mclk) disable iff (sys_rst)
        wr_en && addr == `ECCR_B_CTRL1 && !wr_data[`ECCR_C1_RESET] && !soft_pend
        |=> freeze_adapt[1] == $past(wr_data[`ECCR_C1_FREEZE]) && noise_off[1] == $past(wr_data[`ECCR_C1_NOISE_OFF]))
        else $error("freeze or noise control mismatch");

    chk_noise_follow: assert property (@(posedge mclk) disable iff (sys_rst)
        wr_en && addr == `ECCR_A_CTRL1 && !wr_data[`ECCR_C1_RESET] && !soft_pend
        |=> noise_off[0] == $past(wr_data[`ECCR_C1_NOISE_OFF]) && freeze_adapt[0] == $past(wr_data[`ECCR_C1_FREEZE]))
        else $error("noise or freeze control mismatch");

    chk_tone_ctl_follow: assert property (@(posedge mclk) disable iff (sys_rst)
        wr_en && addr == `ECCR_A_CTRL2 && !soft_pend
        |=> tone_det_off[0] == $past(wr_data[`ECCR_C2_TONE_OFF]) && nlp_off[0] == $past(wr_data[`ECCR_C2_NLP_OFF]))
        else $error("tone or processor control mismatch");

    chk_tone_b_follow: assert property (@(posedge mclk) disable iff (sys_rst)
        wr_en && addr == `ECCR_B_CTRL2 && !soft_pend
        |=> tone_det_off[1] == $past(wr_data[`ECCR_C2_TONE_OFF]))
        else $error("tone detection control mismatch");

    chk_ofs_filter_follow: assert property (@(posedge mclk) disable iff (sys_rst)
        wr_en && addr == `ECCR_B_CTRL2 && !soft_pend
        |=> ofs_filter_off[1] == $past(wr_data[`ECCR_C2_OFS_OFF]))
        else $error("offset filter control mismatch");

    chk_nb_det_follow: assert property (@(posedge mclk) disable iff (sys_rst)
        wr_en && addr == `ECCR_B_CTRL2 && !soft_pend
        |=> nb_det_off[1] == $past(wr_data[`ECCR_C2_NB_OFF]))
        else $error("narrowband detector control mismatch");

    chk_nlp_follow: assert property (@(posedge mclk) disable iff (sys_rst)
        wr_en && addr == `ECCR_B_CTRL2 && !soft_pend
        |=> nlp_off[1] == $past(wr_data[`ECCR_C2_NLP_OFF]))
        else $error("nonlinear processor control mismatch");

    chk_phase_chk_follow: assert property (@(posedge mclk) disable iff (sys_rst)
        wr_en && addr == `ECCR_A_CTRL2 && !soft_pend
        |=> phase_chk_off[0] == $past(wr_data[`ECCR_C2_PHASE_OFF]))
        else $error("phase check control mismatch");
endmodule

/* design/eccr_cfg.svh */
// Offsets, field positions, reset values and fixed figures of the canceller register bank.
// Included by the package and the test modules; holds definitions only.
`ifndef ECCR_CFG_SVH
`define ECCR_CFG_SVH

`define ECCR_ADDR_W        8
`define ECCR_A_CTRL1       8'h00
`define ECCR_A_CTRL2       8'h01
`define ECCR_A_STATE       8'h02
`define ECCR_B_CTRL1       8'h20
`define ECCR_B_CTRL2       8'h21
`define ECCR_B_STATE       8'h22

`define ECCR_A_CTRL1_RST   8'h00
`define ECCR_B_CTRL1_RST   8'h02
`define ECCR_CTRL2_RST     8'h00
`define ECCR_STATE_RST     8'h00

// Control register 1 fields.
`define ECCR_C1_RESET      7
`define ECCR_C1_NOISE_OFF  6
`define ECCR_C1_B2B        5
`define ECCR_C1_BYPASS     4
`define ECCR_C1_PAD        3
`define ECCR_C1_FREEZE     2
`define ECCR_C1_EXTDLY     0

// Control register 2 fields.
`define ECCR_C2_TONE_OFF   7
`define ECCR_C2_PHASE_OFF  6
`define ECCR_C2_NLP_OFF    5
`define ECCR_C2_AUTO_TONE  4
`define ECCR_C2_NB_OFF     3
`define ECCR_C2_OFS_OFF    2
`define ECCR_C2_SEND_MUTE  1
`define ECCR_C2_RECV_MUTE  0

// Pad loss in dB and the linear quiet code.
`define ECCR_PAD_DB        12
`define ECCR_QUIET_CODE    16'h0000
`define ECCR_SAMPLE_W      16

`endif

/* design/eccr_pkg.sv */
// Types shared by the canceller register bank.
// Assumes eccr_cfg.svh is on the include path.
`include "eccr_cfg.svh"
package eccr_pkg;
    typedef logic [7:0] eccr_byte_t;

    // Decoded controls of one canceller.
    typedef struct packed {
        logic freeze_adaptation;
        logic bypass;
        logic pad;
        logic back_to_back_config;
        logic comfort_noise_off;
        logic tone_detection_off;
        logic phase_check_off;
        logic nonlinear_processor_off;
        logic auto_tone;
        logic narrowband_detector_off;
        logic offset_filter_off;
        logic send_output_silence;
        logic receive_output_silence;
    } eccr_ctl_t;
endpackage

/* design/eccr_path.sv */
// Sample path control for one canceller: bypass, 12 dB pad and muting of the outputs.
// Assumes samples are 16-bit linear two's complement and arrive with a one-cycle valid.
`timescale 1ns/1ps
module eccr_path
    import eccr_pkg::*;
#(
    parameter int W = `ECCR_SAMPLE_W
) (
    input  wire logic         mclk,         // Master clock.
    input  wire logic         sys_rst,      // Synchronous reset, active high.
    input  wire logic         bypass,       // Pass inputs straight through.
    input  wire logic         pad,          // Insert pad loss on the receive path.
    input  wire logic         send_mute,    // Force quiet code on send output.
    input  wire logic         recv_mute,    // Force quiet code on receive output.
    input  wire logic         smp_valid,    // Sample strobe.
    input  wire logic [W-1:0] send_in,      // Send input sample.
    input  wire logic [W-1:0] recv_in,      // Receive input sample.
    input  wire logic [W-1:0] send_proc,    // Send sample from the cancellation engine.
    input  wire logic [W-1:0] recv_proc,    // Receive sample from the cancellation engine.
    output logic      [W-1:0] send_out,     // Send output sample.
    output logic      [W-1:0] recv_out      // Receive output sample.
);
    typedef struct packed {
        logic [W-1:0] send_out;
        logic [W-1:0] recv_out;
    } eccr_path_st_t;

    eccr_path_st_t st;
    eccr_path_st_t next_st;

    // 12 dB is a quarter in amplitude; an arithmetic shift is exact enough at this level.
    function automatic logic [W-1:0] pad_loss(input logic [W-1:0] s);
        pad_loss = W'($signed(s) >>> 2);
    endfunction

    always_comb begin
        logic [W-1:0] r;
        r = '0;
        next_st = st;
        if (smp_valid) begin
            next_st.send_out = bypass ? send_in : send_proc;
            r = bypass ? recv_in : recv_proc;
            next_st.recv_out = pad ? pad_loss(r) : r;
            if (send_mute) begin
                next_st.send_out = W'(`ECCR_QUIET_CODE);
            end
            if (recv_mute) begin
                next_st.recv_out = W'(`ECCR_QUIET_CODE);
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign send_out = st.send_out;
    assign recv_out = st.recv_out;

    chk_mute_send_quiet: assert property (@(posedge mclk) disable iff (sys_rst)
        smp_valid && send_mute |=> send_out == W'(`ECCR_QUIET_CODE))
        else $error("send output not quiet while muted");
    chk_bypass_recv_pass: assert property (@(posedge mclk) disable iff (sys_rst)
        smp_valid && bypass && !pad && !recv_mute |=> recv_out == $past(recv_in))
        else $error("receive bypass did not pass input");
    chk_pad_quarter: assert property (@(posedge mclk) disable iff (sys_rst)
        smp_valid && !bypass && pad && !recv_mute |=> recv_out == W'($signed($past(recv_proc)) >>> 2))
        else $error("pad loss not applied");
endmodule

/* test/eccr_host.sv */
// Host model on the register port: issues one-cycle byte writes and reads.
// Assumes strobes are taken on rising mclk and the read answer comes registered.
`timescale 1ns/1ps
`include "eccr_cfg.svh"
module eccr_host (
    input  wire logic       mclk,     // Master clock.
    output logic            wr_en,    // Write strobe.
    output logic            rd_en,    // Read strobe.
    output logic [7:0]      addr,     // Register address.
    output logic [7:0]      wr_data,  // Write byte.
    input  wire logic [7:0] rd_data,  // Read byte.
    input  wire logic       rd_valid  // Read answer strobe.
);
    int gap = 0;

    initial begin
        wr_en = 1'b0;
        rd_en = 1'b0;
        addr = 8'h00;
        wr_data = 8'h00;
    end

    task automatic write(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] v;
        v = d;
        if (a == `ECCR_A_CTRL1) begin
            // Bit 0 of canceller A is the extended-delay control, so only bit 1 is reserved.
            v[1] = 1'b0;
        end
        if (a == `ECCR_B_CTRL1) begin
            v[1:0] = 2'b10;
        end
        if (a == `ECCR_A_CTRL1 && v[`ECCR_C1_B2B]) begin
            v[`ECCR_C1_EXTDLY] = 1'b0;
        end
        repeat (gap) @(posedge mclk);
        @(posedge mclk);
        #1;
        addr = a;
        wr_data = v;
        wr_en = 1'b1;
        @(posedge mclk);
        #1;
        wr_en = 1'b0;
        // Released lines show the inverse so a stale value never passes for a live one.
        addr = ~a;
        wr_data = ~v;
    endtask

    task automatic read(input logic [7:0] a, output logic [7:0] d);
        int n;
        repeat (gap) @(posedge mclk);
        @(posedge mclk);
        #1;
        addr = a;
        rd_en = 1'b1;
        @(posedge mclk);
        #1;
        rd_en = 1'b0;
        addr = ~a;
        n = 0;
        while (rd_valid !== 1'b1 && n < 4) begin
            @(posedge mclk);
            #1;
            n++;
        end
        d = (rd_valid === 1'b1) ? rd_data : 8'hXX;
    endtask
endmodule

/* test/tb_echo_canceller_control_regs.sv */
// Self-checking bench of the canceller register bank and its sample path.
// Assumes the host model drives the register port and the bench drives the rest.
`timescale 1ns/1ps
`include "eccr_cfg.svh"
`define CHECK(got, exp) begin \
    comparisons++; \
    if ((got) !== (exp)) begin \
        num_errors++; \
        $display("mismatch at %0t: got %h expected %h", $time, got, exp); \
    end \
end
module tb_echo_canceller_control_regs;
    import eccr_pkg::*;
    logic        mclk, sys_rst, wr_en, rd_en, rd_valid, smp_valid, cascade, b2b_config;
    logic [7:0]  addr, wr_data, rd_data, state_a_in, state_b_in;
    logic [1:0]  freeze_adapt, noise_off, ofs_filter_off, nb_det_off, nlp_off;
    logic [1:0]  phase_chk_off, tone_det_off, auto_tone;
    logic [31:0] send_in, recv_in, send_proc, recv_proc, send_out, recv_out;
    logic [17:0] ctl;
    int          num_errors, comparisons, cycles;

    assign ctl = {cascade, b2b_config, freeze_adapt, noise_off, ofs_filter_off, nb_det_off,
                  nlp_off, phase_chk_off, tone_det_off, auto_tone};

    eccr_host host_u (.mclk(mclk), .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wr_data(wr_data),
                      .rd_data(rd_data), .rd_valid(rd_valid));

    eccr_regs dut_u (.mclk(mclk), .sys_rst(sys_rst), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
        .wr_data(wr_data), .rd_data(rd_data), .rd_valid(rd_valid), .state_a_in(state_a_in),
        .state_b_in(state_b_in), .cascade(cascade), .b2b_config(b2b_config),
        .freeze_adapt(freeze_adapt), .noise_off(noise_off), .ofs_filter_off(ofs_filter_off),
        .nb_det_off(nb_det_off), .nlp_off(nlp_off), .phase_chk_off(phase_chk_off),
        .tone_det_off(tone_det_off), .auto_tone(auto_tone), .smp_valid(smp_valid),
        .send_in(send_in), .recv_in(recv_in), .send_proc(send_proc), .recv_proc(recv_proc),
        .send_out(send_out), .recv_out(recv_out));

    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    task automatic stop_test();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // The whole run needs well under a thousand cycles.
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            stop_test();
        end
    end

    function automatic logic [17:0] exp_ctl(input logic [7:0] a1, a2, b1, b2);
        return {a1[0], a1[5], b1[2], a1[2], b1[6], a1[6], b2[2], a2[2], b2[3], a2[3],
                b2[5], a2[5], b2[6], a2[6], b2[7], a2[7], b2[4], a2[4]};
    endfunction

    task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] v;
        host_u.read(a, v);
        `CHECK(v, e)
    endtask

    task automatic chk_rst();
        logic [7:0] regs [7];
        logic [7:0] rstv [7];
        regs = '{8'h00, 8'h01, 8'h02, 8'h20, 8'h21, 8'h22, 8'h10};
        rstv = '{8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00};
        `CHECK(ctl, 18'h00000)
        foreach (regs[i]) chk_rd(regs[i], rstv[i]);
    endtask

    // Writes all four control registers, reads them back, then runs one sample through.
    task automatic run_cfg(input logic [7:0] a1, a2, b1, b2, input logic [31:0] es, er);
        host_u.write(8'h00, a1);
        host_u.write(8'h01, a2);
        host_u.write(8'h20, b1);
        host_u.write(8'h21, b2);
        @(posedge mclk);
        #1;
        `CHECK(ctl, exp_ctl(a1, a2, b1, b2))
        chk_rd(8'h00, a1);
        chk_rd(8'h01, a2);
        chk_rd(8'h20, b1);
        chk_rd(8'h21, b2);
        smp_valid = 1'b1;
        @(posedge mclk);
        #1;
        smp_valid = 1'b0;
        @(posedge mclk);
        #1;
        `CHECK(send_out, es)
        `CHECK(recv_out, er)
    endtask

    initial begin
        sys_rst = 1'b1;
        smp_valid = 1'b0;
        state_a_in = 8'h00;
        state_b_in = 8'h00;
        send_in = 32'h1111_2222;
        recv_in = 32'h3333_8004;
        send_proc = 32'h4444_5555;
        recv_proc = 32'h6666_7777;
        repeat (4) @(posedge mclk);
        #1;
        sys_rst = 1'b0;
        chk_rst();
        run_cfg(8'h5D, 8'hA5, 8'h46, 8'h5A, 32'h0000_2222, 32'h6666_0000);
        host_u.gap = 2;
        // Both back-to-back bits move together.
        run_cfg(8'h20, 8'h5A, 8'h3E, 8'hA5, 32'h1111_0000, 32'h0000_7777);
        host_u.gap = 0;
        run_cfg(8'h18, 8'h00, 8'h0A, 8'h00, 32'h4444_2222, 32'h1999_E001);
        for (int i = 0; i < 2; i++) begin
            host_u.write(8'h01, 8'hFF);
            host_u.write(8'h21, 8'hFF);
            host_u.write(i ? 8'h20 : 8'h00, i ? 8'h82 : 8'h80);
            repeat (2) @(posedge mclk);
            #1;
            chk_rst();
        end
        host_u.write(8'h01, 8'h3C);
        chk_rd(8'h01, 8'h3C);
        state_a_in = 8'h3C;
        state_b_in = 8'hC3;
        host_u.write(8'h02, 8'hFF);
        host_u.write(8'h22, 8'h00);
        host_u.write(8'h10, 8'hFF);
        chk_rd(8'h02, 8'h3C);
        chk_rd(8'h22, 8'hC3);
        chk_rd(8'h10, 8'h00);
        stop_test();
    end
endmodule
